// file: verif/acq_chk.sv
// Assertion checker bound to the acquisition mode selector.
`timescale 1ns/100ps
module acq_chk
  import acq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] overload_detect,
  input wire logic [1:0] vernier_off_detent,
  input wire logic sample_strobe,
  input mode_type acq_mode_q,
  input wire logic repetitive_interleave_mode_q,
  input wire logic [31:0] sample_interval_q,
  input wire logic [14:0] record_length_q,
  input wire logic acq_restart_q,
  input wire logic display_update_q,
  input vert_type [1:0] gain_scale_setting_q,
  input wire logic [1:0] input_overload_flag_q,
  input wire logic [1:0] signal_disconnect_q,
  input wire logic [1:0] gain_uncal_q,
  input wire logic [1:0] offscreen_up_q
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence trip0;
    overload_detect[0] && gain_scale_setting_q[0].coupling == CPL_DC_50;
  endsequence
  sequence tripped0;
    input_overload_flag_q[0] && signal_disconnect_q[0] &&
    gain_scale_setting_q[0].coupling == CPL_GND;
  endsequence
  a_mode_flag: assert property (
    repetitive_interleave_mode_q == (acq_mode_q == INTERLEAVED))
    else $error("interleave flag disagrees with mode");
  a_ris_pair: assert property (
    acq_mode_q == INTERLEAVED |->
    (record_length_q == READ_LEN_RIS && sample_interval_q == RIS_UNITS)
    || (record_length_q == READ_LEN_RIS_1US && sample_interval_q == RIS_1US_UNITS)
    || (record_length_q == READ_LEN_RIS_2US && sample_interval_q == RIS_2US_UNITS))
    else $error("interleaved interval or length wrong");
  a_ss_floor: assert property (
    acq_mode_q != INTERLEAVED && record_length_q != 15'h0000 |->
    record_length_q == READ_LEN_FULL && sample_interval_q >= SS_MIN_UNITS)
    else $error("single or roll interval or length wrong");
  a_roll_update: assert property (
    sample_strobe && acq_mode_q == ROLL_MODE |=> display_update_q)
    else $error("roll sample did not update display");
  a_overload_trip: assert property (
    trip0 |=> tripped0)
    else $error("overload did not disconnect");
  a_flag_release: assert property (
    $fell(input_overload_flag_q[0]) |->
    gain_scale_setting_q[0].coupling == CPL_DC_50 && !$past(overload_detect[0]))
    else $error("overload flag cleared wrongly");
  a_uncal_follow: assert property (
    $past(presetn) |-> gain_uncal_q == $past(vernier_off_detent))
    else $error("uncalibrated mark wrong");
  a_offscreen_up: assert property (
    $past(presetn) |-> offscreen_up_q[0] == ($past(gain_scale_setting_q[0].offset) > OFS_GRID))
    else $error("off screen indicator wrong");
  a_restart_pulse: assert property (
    $past(presetn) && $past(presetn, 2) && $changed(sample_interval_q) |-> acq_restart_q)
    else $error("setting change without restart");
endmodule
bind acquisition_mode_selector acq_chk acq_chk_inst (.*);

// file: verif/acquisition_mode_selector_test.sv
// Self-checking bench for the acquisition mode selector.
`timescale 1ns/100ps
module acquisition_mode_selector_test;
  import acq_pkg::*;
  logic pclk = 1'h0;
  logic presetn, psel, penable, pwrite, trigger, sample_strobe, fire, err;
  logic pready_q, pslverr_q, acq_restart_q, display_update_q, irq_q;
  logic repetitive_interleave_mode_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_q, rd, sample_interval_q;
  logic [14:0] record_length_q;
  logic [1:0] overload_detect, vernier_off_detent, signal_hot, at_50;
  logic [1:0] signal_disconnect_q, input_overload_flag_q, gain_uncal_q;
  logic [1:0] offscreen_up_q, offscreen_down_q;
  mode_type acq_mode_q;
  vert_type [1:0] gain_scale_setting_q;
  int num_errors, n_checks;
  acquisition_mode_selector acquisition_mode_selector_inst (.*);
  assign at_50 = {gain_scale_setting_q[1].coupling == CPL_DC_50,
                  gain_scale_setting_q[0].coupling == CPL_DC_50};
  front_end_model front_end_model_inst (.pclk(pclk), .presetn(presetn), .signal_hot(signal_hot),
    .at_50_ohm(at_50), .disconnect(signal_disconnect_q), .fire(fire),
    .overload_detect(overload_detect), .sample_strobe(sample_strobe), .trigger(trigger));
  always #4 pclk = ~pclk;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Holds the request until pready is seen, then lets an edge pass before the next one.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'h1 && n < 16);
    if (n >= 16) begin
      num_errors++;
      give_verdict();
    end
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic t_bus();
    apb(1'h0, ADDR_TIMEBASE, 32'h0);
    chk(rd, 32'h0, "timebase reset");
    apb(1'h0, 8'h30, 32'h0);
    chk(err, 1'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'h1, ADDR_MODE, 32'hffff_ffff);
    apb(1'h0, ADDR_MODE, 32'h0);
    chk(rd, {1'h0, 15'h5dc0, 14'h0, 2'h1}, "read only mode");
    $display("bus test done");
  endtask
  task automatic t_modes();
    logic [6:0] prev;
    longint ns;
    mode_type m;
    logic [14:0] len;
    logic [31:0] iv;
    prev = 7'h00;
    for (int r = 0; r < 2; r++) begin
      for (int s = 0; s <= 32; s++) begin
        ns = (s % 3 == 0) ? 2 : (s % 3 == 1) ? 5 : 10;
        for (int k = 0; k < s / 3; k++) ns *= 10;
        m = ns <= 20 || (ns <= 2000 && r == 1) ? INTERLEAVED :
            ns >= 500000000 ? ROLL_MODE : SINGLE_SHOT;
        len = m != INTERLEAVED ? 15'h7d00 : ns == 1000 ? 15'h60e0
            : ns == 2000 ? 15'h61a8 : 15'h5dc0;
        iv = m == INTERLEAVED ? (ns == 1000 ? 2 : ns == 2000 ? 4 : 1)
            : 32'(ns / 500 > 50 ? ns / 500 : 50);
        apb(1'h1, ADDR_TIMEBASE, {23'h0, r[0], 2'h0, s[5:0]});
        @(posedge pclk);
        chk(acq_restart_q, {s[5:0], r[0]} != prev, "restart");
        chk(acq_mode_q, m, "mode");
        chk(record_length_q, len, "length");
        chk(sample_interval_q, iv, "interval");
        @(posedge pclk);
        chk(acq_restart_q, 1'h0, "restart pulse");
        apb(1'h0, ADDR_MODE, 32'h0);
        chk(rd, {1'h0, len, 14'h0, m}, "mode register");
        prev = {s[5:0], r[0]};
      end
    end
    $display("mode test done");
  endtask
  task automatic t_irq();
    apb(1'h1, ADDR_INT_STATUS, 32'hf);
    apb(1'h1, ADDR_INT_MASK, 32'h0);
    apb(1'h1, ADDR_TIMEBASE, 32'h5);
    repeat (2) @(posedge pclk);
    chk(irq_q, 1'h0, "masked irq");
    apb(1'h1, ADDR_INT_MASK, 32'h8);
    @(posedge pclk);
    chk(irq_q, 1'h1, "irq");
    apb(1'h1, ADDR_INT_STATUS, 32'h8);
    @(posedge pclk);
    chk(irq_q, 1'h0, "irq clear");
    $display("irq test done");
  endtask
  task automatic t_vert();
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, ADDR_VERT1, {26'h0, c[1:0], 4'ha});
      chk(gain_scale_setting_q[1].coupling, c, "coupling");
      chk(gain_scale_setting_q[1].gain, c == 3 ? 4'h7 : 4'h9, "top gain");
    end
    apb(1'h1, ADDR_VERT0, 32'h39);
    signal_hot[0] <= 1'h1;
    repeat (3) @(posedge pclk);
    chk({input_overload_flag_q[0], signal_disconnect_q[0]}, 2'h3, "trip");
    chk(gain_scale_setting_q[0].coupling, CPL_GND, "ground");
    apb(1'h1, ADDR_VERT0, 32'h39);
    repeat (2) @(posedge pclk);
    chk(input_overload_flag_q[0], 1'h1, "signal still on");
    signal_hot[0] <= 1'h0;
    apb(1'h1, ADDR_VERT0, 32'h39);
    chk({input_overload_flag_q[0], at_50[0]}, 2'h1, "flag cleared");
    $display("vertical test done");
  endtask
  task automatic t_offset();
    logic [15:0] v [4];
    logic [1:0] e [4];
    v = '{16'h0065, 16'hff9b, 16'h0064, 16'h012c};
    e = '{2'h1, 2'h2, 2'h0, 2'h1};
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, ADDR_VERT0, {v[i], 16'h0039});
      @(posedge pclk);
      chk({offscreen_down_q[0], offscreen_up_q[0]}, e[i], "off screen");
    end
    chk(gain_scale_setting_q[0].offset, 9'h0c8, "offset limit");
    $display("offset test done");
  endtask
  task automatic t_trace();
    logic [31:0] old;
    apb(1'h0, ADDR_TRACE, 32'h0);
    old = rd;
    vernier_off_detent <= 2'h1;
    apb(1'h1, ADDR_TIMEBASE, 32'h7);
    @(posedge pclk);
    apb(1'h0, ADDR_SUMMARY, 32'h0);
    chk({rd[21:20], rd[6:0]}, 9'h087, "summary");
    apb(1'h0, ADDR_TRACE, 32'h0);
    chk(rd, old, "trace held");
    fire <= 1'h1;
    @(posedge pclk);
    fire <= 1'h0;
    apb(1'h0, ADDR_TRACE, 32'h0);
    chk({rd[21:20], rd[6:0]}, 9'h087, "trace latch");
    chk(gain_uncal_q, 2'h1, "uncal");
    $display("trace test done");
  endtask
  task automatic t_roll();
    int hits;
    for (int k = 0; k < 2; k++) begin
      apb(1'h1, ADDR_TIMEBASE, k == 0 ? 32'h19 : 32'h18);
      hits = 0;
      repeat (16) begin
        @(posedge pclk);
        hits += display_update_q;
      end
      chk(hits > 2, k == 0, "roll updates");
    end
    $display("roll test done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, fire} = 5'h00;
    {paddr, pwdata, vernier_off_detent, signal_hot} = 44'h0;
    num_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_bus();
    t_modes();
    t_irq();
    t_vert();
    t_offset();
    t_trace();
    t_roll();
    give_verdict();
  end
endmodule

// file: verif/front_end_model.sv
// Analog front end model: input power, converter strobes and trigger.
`timescale 1ns/100ps
module front_end_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] signal_hot,
  input wire logic [1:0] at_50_ohm,
  input wire logic [1:0] disconnect,
  input wire logic fire,
  output logic [1:0] overload_detect,
  output logic sample_strobe,
  output logic trigger
);
  logic [1:0] div_q;
  // The sensor sits ahead of the relay, so a live signal still reads high while disconnected.
  assign overload_detect = signal_hot & (at_50_ohm | disconnect);
  assign sample_strobe = div_q == 2'h3;
  assign trigger = fire;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
endmodule

// file: verilog/acq_pkg.sv
// Constants, types and helper functions shared by the acquisition mode selector.
package acq_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_TIMEBASE = 8'h00;
  localparam logic [7:0] ADDR_VERT0 = 8'h04;
  localparam logic [7:0] ADDR_VERT1 = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0c;
  localparam logic [7:0] ADDR_INTERVAL = 8'h10;
  localparam logic [7:0] ADDR_SUMMARY = 8'h14;
  localparam logic [7:0] ADDR_TRACE = 8'h18;
  localparam logic [7:0] ADDR_FLAGS = 8'h1c;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h20;
  localparam logic [7:0] ADDR_INT_MASK = 8'h24;

  // Field positions.
  localparam int TB_STEP_LSB = 0;
  localparam int TB_REQ_BIT = 8;
  localparam int VERT_GAIN_LSB = 0;
  localparam int VERT_CPL_LSB = 4;
  localparam int VERT_OFS_LSB = 16;
  localparam int MODE_LEN_LSB = 16;

  // Time base steps: step 0 is 2 ns/div, step 32 is 100 s/div, 1-2-5 sequence.
  localparam logic [5:0] TB_STEP_MAX = 6'h20;
  localparam logic [5:0] RIS_FORCED_MAX = 6'h03;
  localparam logic [5:0] RIS_OPTION_MAX = 6'h09;
  localparam logic [5:0] ROLL_MIN_STEP = 6'h19;
  localparam logic [5:0] STEP_1US = 6'h08;
  localparam logic [5:0] STEP_2US = 6'h09;
  localparam int DECADES_MAX = 11;

  // Sample intervals are reported in units of the 200 ps interleaved interval.
  localparam int RIS_INTERVAL_PS = 200;
  localparam int SS_MIN_INTERVAL_PS = 10000;
  localparam int GRID_DIVS = 10;
  localparam int RECORD_POINTS = 25000;
  localparam logic [55:0] SS_SCALE_NUM = 56'(1000 * GRID_DIVS);
  localparam logic [55:0] SS_SCALE_DEN = 56'(RECORD_POINTS * RIS_INTERVAL_PS);
  localparam logic [31:0] SS_MIN_UNITS = 32'(SS_MIN_INTERVAL_PS / RIS_INTERVAL_PS);
  localparam logic [31:0] RIS_UNITS = 32'h0000_0001;
  localparam logic [31:0] RIS_1US_UNITS = 32'h0000_0002;
  localparam logic [31:0] RIS_2US_UNITS = 32'h0000_0004;

  // Remote readout lengths in words.
  localparam logic [14:0] READ_LEN_FULL = 15'h7d00;
  localparam logic [14:0] READ_LEN_RIS = 15'h5dc0;
  localparam logic [14:0] READ_LEN_RIS_1US = 15'h60e0;
  localparam logic [14:0] READ_LEN_RIS_2US = 15'h61a8;

  // Vertical: gain step 0 is 5 mV/div, step 7 is 1 V/div, step 9 is 5 V/div.
  localparam logic [3:0] GAIN_MAX_HIZ = 4'h9;
  localparam logic [3:0] GAIN_MAX_50 = 4'h7;
  localparam int VERNIER_MAX_MV = 12500;
  // Offset in steps of 0.04 division: 200 steps is 8 divisions, 100 is the grid edge.
  localparam logic signed [8:0] OFS_MAX = 9'sh0c8;
  localparam logic signed [8:0] OFS_GRID = 9'sh064;
  localparam int OVERLOAD_MW = 500;

  // Interrupt status bits.
  localparam int INT_W = 4;
  localparam int INT_OVL0 = 0;
  localparam int INT_OVL1 = 1;
  localparam int INT_TRIG = 2;
  localparam int INT_RESTART = 3;

  typedef enum logic [1:0] {SINGLE_SHOT, INTERLEAVED, ROLL_MODE} mode_type;
  typedef enum logic [1:0] {CPL_AC, CPL_GND, CPL_DC_HIZ, CPL_DC_50} coupling_type;

  typedef struct packed {
    logic [3:0] gain;
    coupling_type coupling;
    logic signed [8:0] offset;
  } vert_type;

  typedef struct packed {
    mode_type mode;
    logic [31:0] interval;
    logic [14:0] length;
  } acq_type;

  // Time per division in nanoseconds for a step.
  function automatic logic [39:0] tdiv_ns(input logic [5:0] step);
    logic [6:0] pos;
    logic [39:0] v;
    pos = 7'(step) + 7'h01;
    unique case (pos % 7'h03)
      7'h00: v = 40'h1;
      7'h01: v = 40'h2;
      default: v = 40'h5;
    endcase
    for (int i = 0; i < DECADES_MAX; i++) begin
      if (7'(i) < pos / 7'h03) begin
        v = v * 40'ha;
      end
    end
    return v;
  endfunction

endpackage

// file: verilog/acquisition_mode_selector.sv
// Acquisition mode selector with vertical controls, overload guard and APB registers.
`timescale 1ns/100ps
module acquisition_mode_selector
  import acq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  input wire logic [1:0] overload_detect,
  input wire logic [1:0] vernier_off_detent,
  input wire logic trigger,
  input wire logic sample_strobe,
  output mode_type acq_mode_q,
  output logic repetitive_interleave_mode_q,
  output logic [31:0] sample_interval_q,
  output logic [14:0] record_length_q,
  output logic acq_restart_q,
  output logic display_update_q,
  output vert_type [1:0] gain_scale_setting_q,
  output logic [1:0] signal_disconnect_q,
  output logic [1:0] input_overload_flag_q,
  output logic [1:0] gain_uncal_q,
  output logic [1:0] offscreen_up_q,
  output logic [1:0] offscreen_down_q,
  output logic irq_q
);

  logic [5:0] tb_step_q;
  logic interleave_req_q;
  logic [6:0] prev_key_q;
  logic [31:0] summary_q;
  logic [31:0] trace_q;
  logic [INT_W-1:0] int_status_q;
  logic [INT_W-1:0] int_mask_q;
  logic [INT_W-1:0] int_status_d;
  logic [INT_W-1:0] int_event;
  logic [1:0] ovl_set;
  logic [1:0] ovl_clr;
  logic [1:0] vert_wr;
  logic wr_en;
  acq_type acq_d;
  logic [31:0] summary_d;
  logic [31:0] rd_d;
  logic rd_ok;

  // Highest gain step the coupling allows.
  function automatic logic [3:0] gain_limit(input logic [3:0] g, input coupling_type c);
    logic [3:0] top;
    top = (c == CPL_DC_50) ? GAIN_MAX_50 : GAIN_MAX_HIZ;
    return (g > top) ? top : g;
  endfunction

  // Saturate a requested offset to one grid height either way.
  function automatic logic signed [8:0] ofs_limit(input logic signed [15:0] o);
    logic signed [8:0] r;
    r = o[8:0];
    if (o > 16'(OFS_MAX)) begin
      r = OFS_MAX;
    end else if (o < -16'(OFS_MAX)) begin
      r = -OFS_MAX;
    end
    return r;
  endfunction

  // Sampling mode, interval and readout length for a time base step.
  function automatic acq_type derive_acq(input logic [5:0] step, input logic req);
    acq_type a;
    logic [55:0] ivl;
    ivl = 56'(tdiv_ns(step)) * SS_SCALE_NUM / SS_SCALE_DEN;
    a.mode = SINGLE_SHOT;
    a.interval = ivl[31:0];
    a.length = READ_LEN_FULL;
    if (ivl < 56'(SS_MIN_UNITS)) begin
      a.interval = SS_MIN_UNITS;
    end
    if (step >= ROLL_MIN_STEP) begin
      a.mode = ROLL_MODE;
    end else if (step <= RIS_FORCED_MAX || (req && step <= RIS_OPTION_MAX)) begin
      a.mode = INTERLEAVED;
      a.interval = RIS_UNITS;
      a.length = READ_LEN_RIS;
      if (step == STEP_1US) begin
        a.interval = RIS_1US_UNITS;
        a.length = READ_LEN_RIS_1US;
      end else if (step == STEP_2US) begin
        a.interval = RIS_2US_UNITS;
        a.length = READ_LEN_RIS_2US;
      end
    end
    return a;
  endfunction

  // Mode follows the current settings without waiting for a trigger.
  always_comb begin
    acq_d = derive_acq(tb_step_q, interleave_req_q);
  end

  always_comb begin
    summary_d = 32'h0;
    summary_d[5:0] = tb_step_q;
    summary_d[6] = interleave_req_q;
    summary_d[11:8] = gain_scale_setting_q[0].gain;
    summary_d[15:12] = gain_scale_setting_q[1].gain;
    summary_d[17:16] = gain_scale_setting_q[0].coupling;
    summary_d[19:18] = gain_scale_setting_q[1].coupling;
    summary_d[21:20] = vernier_off_detent;
  end

  // APB: no wait states; pready and read data are registered in the setup cycle, so every read answer comes from a flip-flop.
  assign wr_en = psel & penable & pwrite & pready_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~rd_ok;
      prdata_q <= (psel & ~penable & ~pwrite) ? rd_d : 32'h0;
    end
  end

  always_comb begin
    rd_d = 32'h0;
    rd_ok = 1'b1;
    unique case (paddr)
      ADDR_TIMEBASE: begin
        rd_d[TB_STEP_LSB +: 6] = tb_step_q;
        rd_d[TB_REQ_BIT] = interleave_req_q;
      end
      ADDR_VERT0, ADDR_VERT1: begin
        rd_d[VERT_GAIN_LSB +: 4] = gain_scale_setting_q[paddr[3]].gain;
        rd_d[VERT_CPL_LSB +: 2] = gain_scale_setting_q[paddr[3]].coupling;
        rd_d[VERT_OFS_LSB +: 16] = 16'(gain_scale_setting_q[paddr[3]].offset);
      end
      ADDR_MODE: begin
        rd_d[1:0] = acq_mode_q;
        rd_d[MODE_LEN_LSB +: 15] = record_length_q;
      end
      ADDR_INTERVAL: rd_d = sample_interval_q;
      ADDR_SUMMARY: rd_d = summary_q;
      ADDR_TRACE: rd_d = trace_q;
      ADDR_FLAGS: begin
        rd_d[1:0] = input_overload_flag_q;
        rd_d[3:2] = gain_uncal_q;
        rd_d[5:4] = offscreen_up_q;
        rd_d[7:6] = offscreen_down_q;
      end
      ADDR_INT_STATUS: rd_d[INT_W-1:0] = int_status_q;
      ADDR_INT_MASK: rd_d[INT_W-1:0] = int_mask_q;
      default: rd_ok = 1'b0;
    endcase
  end

  // Time base settings; steps past 100 s/div are clamped rather than wrapped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_step_q <= 6'h0;
      interleave_req_q <= 1'b0;
    end else if (wr_en && paddr == ADDR_TIMEBASE) begin
      tb_step_q <= (pwdata[TB_STEP_LSB +: 6] > TB_STEP_MAX) ? TB_STEP_MAX
                   : pwdata[TB_STEP_LSB +: 6];
      interleave_req_q <= pwdata[TB_REQ_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_mode_q <= SINGLE_SHOT;
      repetitive_interleave_mode_q <= 1'b0;
      sample_interval_q <= 32'h0;
      record_length_q <= 15'h0;
      prev_key_q <= 7'h0;
      acq_restart_q <= 1'b0;
      display_update_q <= 1'b0;
    end else begin
      acq_mode_q <= acq_d.mode;
      repetitive_interleave_mode_q <= (acq_d.mode == INTERLEAVED);
      sample_interval_q <= acq_d.interval;
      record_length_q <= acq_d.length;
      prev_key_q <= {interleave_req_q, tb_step_q};
      acq_restart_q <= ({interleave_req_q, tb_step_q} != prev_key_q);
      display_update_q <= sample_strobe & (acq_mode_q == ROLL_MODE);
    end
  end

  // Overload is only meaningful into the 50 ohm termination.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      vert_wr[c] = wr_en && paddr == (c == 0 ? ADDR_VERT0 : ADDR_VERT1);
      ovl_set[c] = overload_detect[c] && gain_scale_setting_q[c].coupling == CPL_DC_50;
      ovl_clr[c] = vert_wr[c] && !overload_detect[c]
                   && pwdata[VERT_CPL_LSB +: 2] == CPL_DC_50;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_scale_setting_q <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (ovl_set[c]) begin
          gain_scale_setting_q[c].coupling <= CPL_GND;
        end else if (vert_wr[c]) begin
          gain_scale_setting_q[c].coupling <= coupling_type'(pwdata[VERT_CPL_LSB +: 2]);
        end
        if (vert_wr[c]) begin
          gain_scale_setting_q[c].gain <= gain_limit(pwdata[VERT_GAIN_LSB +: 4],
            coupling_type'(pwdata[VERT_CPL_LSB +: 2]));
          gain_scale_setting_q[c].offset <= ofs_limit(pwdata[VERT_OFS_LSB +: 16]);
        end
      end
    end
  end

  // A fresh overload wins over a reselection in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_overload_flag_q <= 2'b00;
      signal_disconnect_q <= 2'b00;
    end else begin
      input_overload_flag_q <= ovl_set | (input_overload_flag_q & ~ovl_clr);
      signal_disconnect_q <= ovl_set | (input_overload_flag_q & ~ovl_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_uncal_q <= 2'b00;
      offscreen_up_q <= 2'b00;
      offscreen_down_q <= 2'b00;
    end else begin
      gain_uncal_q <= vernier_off_detent;
      for (int c = 0; c < 2; c++) begin
        offscreen_up_q[c] <= gain_scale_setting_q[c].offset > OFS_GRID;
        offscreen_down_q[c] <= gain_scale_setting_q[c].offset < -OFS_GRID;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summary_q <= 32'h0;
      trace_q <= 32'h0;
    end else begin
      summary_q <= summary_d;
      if (trigger) begin
        trace_q <= summary_d;
      end
    end
  end

  // Interrupts: sticky status, write one to clear, a new event beats the clear.
  always_comb begin
    int_event = '0;
    int_event[INT_OVL0] = ovl_set[0] & ~input_overload_flag_q[0];
    int_event[INT_OVL1] = ovl_set[1] & ~input_overload_flag_q[1];
    int_event[INT_TRIG] = trigger;
    int_event[INT_RESTART] = acq_restart_q;
    int_status_d = int_status_q;
    if (wr_en && paddr == ADDR_INT_STATUS) begin
      int_status_d = int_status_q & ~pwdata[INT_W-1:0];
    end
    int_status_d = int_status_d | int_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_q <= '0;
      int_mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      int_status_q <= int_status_d;
      // The level follows the mask that will stand after this edge, so it never lags it.
      if (wr_en && paddr == ADDR_INT_MASK) begin
        int_mask_q <= pwdata[INT_W-1:0];
        irq_q <= |(int_status_d & pwdata[INT_W-1:0]);
      end else begin
        irq_q <= |(int_status_d & int_mask_q);
      end
    end
  end

endmodule
